// ---- pkg/csa_pkg.sv ----
// Shared constants and types for the core status and working register file
package csa_pkg;
   // Special-function register addresses
   localparam logic [7:0] ADDR_STACK_TOP_POINTER = 8'h81;
   localparam logic [7:0] ADDR_DATA_PTR_LOW_BYTE = 8'h82;
   localparam logic [7:0] ADDR_DATA_PTR_HIGH_BYTE = 8'h83;
   localparam logic [7:0] ADDR_PROGRAM_STATUS_WORD = 8'hd0;
   localparam logic [7:0] ADDR_PRIMARY_WORKING_REGISTER = 8'he0;
   localparam logic [7:0] ADDR_SECONDARY_OPERAND_REGISTER = 8'hf0;
   localparam logic [7:0] SFR_SPACE_BASE = 8'h80;
   // Reset values
   localparam logic [7:0] RST_STACK_TOP_POINTER = 8'h07;
   localparam logic [7:0] RST_DATA_PTR = 8'h00;
   localparam logic [7:0] RST_PROGRAM_STATUS_WORD = 8'h00;
   localparam logic [7:0] RST_PRIMARY_WORKING_REGISTER = 8'h00;
   localparam logic [7:0] RST_SECONDARY_OPERAND_REGISTER = 8'h00;
   // Status word field positions
   localparam int POS_CARRY_FLAG = 7;
   localparam int POS_AUX_CARRY_FLAG = 6;
   localparam int POS_USER_FLAG_ZERO = 5;
   localparam int POS_BANK_SEL_HI = 4;
   localparam int POS_BANK_SEL_LO = 3;
   localparam int POS_ARITH_RANGE_ERROR_FLAG = 2;
   localparam int POS_USER_FLAG_ONE = 1;
   localparam int POS_PARITY_FLAG = 0;
   // Bank base step (eight registers per bank)
   localparam int BANK_SHIFT = 3;
   // Count of low address bits that are zero on bit-addressable registers
   localparam int BIT_ADDR_ALIGN = 3;
   // Arithmetic operation codes
   typedef enum logic [2:0] {
      CSA_OP_NONE = 3'b000,
      CSA_OP_ADD = 3'b001,
      CSA_OP_ADDC = 3'b010,
      CSA_OP_SUBB = 3'b011,
      CSA_OP_MUL = 3'b100,
      CSA_OP_DIV = 3'b101,
      CSA_OP_OTHER = 3'b110
   } csa_op_t;
endpackage

// ---- design/csa_arith_unit.sv ----
// Arithmetic unit producing results and status flags
`timescale 1ns/1ps
module csa_arith_unit
   import csa_pkg::*;
(
   // Operation and operands
   input wire csa_pkg::csa_op_t i_op,
   input wire logic [7:0] i_acc,
   input wire logic [7:0] i_opnd,
   input wire logic [7:0] i_breg,
   input wire logic i_carry_in,
   // Results
   output logic [7:0] o_acc_res,
   output logic [7:0] o_b_res,
   output logic o_b_wr,
   output logic o_carry,
   output logic o_aux_carry,
   output logic o_range_err
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic [15:0] prod;
   logic cin;

   // Result and flag computation
   always_comb begin
      cin = (i_op == CSA_OP_ADDC || i_op == CSA_OP_SUBB) ? i_carry_in
         : 1'b0;
      sum = 9'h000;
      nib = 5'h00;
      prod = 16'h0000;
      o_acc_res = i_acc;
      o_b_res = i_breg;
      o_b_wr = 1'b0;
      o_carry = 1'b0;
      o_aux_carry = 1'b0;
      o_range_err = 1'b0;
      unique case (i_op)
         CSA_OP_ADD, CSA_OP_ADDC: begin
            sum = {1'b0, i_acc} + {1'b0, i_opnd} + {8'h00, cin};
            nib = {1'b0, i_acc[3:0]} + {1'b0, i_opnd[3:0]} + {4'h0, cin};
            o_acc_res = sum[7:0];
            o_carry = sum[8]; // RULE_11
            o_aux_carry = nib[4]; // RULE_11
            o_range_err = (i_acc[7] == i_opnd[7]) &&
               (sum[7] != i_acc[7]); // RULE_12
         end
         CSA_OP_SUBB: begin
            sum = {1'b0, i_acc} - {1'b0, i_opnd} - {8'h00, cin};
            nib = {1'b0, i_acc[3:0]} - {1'b0, i_opnd[3:0]} - {4'h0, cin};
            o_acc_res = sum[7:0];
            o_carry = sum[8]; // RULE_11
            o_aux_carry = nib[4]; // RULE_11
            o_range_err = (i_acc[7] != i_opnd[7]) &&
               (sum[7] != i_acc[7]); // RULE_12
         end
         CSA_OP_MUL: begin
            prod = i_acc * i_breg;
            o_acc_res = prod[7:0];
            o_b_res = prod[15:8];
            o_b_wr = 1'b1;
            o_range_err = (prod[15:8] != 8'h00); // RULE_12
         end
         CSA_OP_DIV: begin
            o_b_wr = 1'b1;
            if (i_breg == 8'h00) begin
               o_range_err = 1'b1; // RULE_12
            end else begin
               o_acc_res = i_acc / i_breg;
               o_b_res = i_acc % i_breg;
            end
         end
         default: begin
            o_acc_res = i_acc;
         end
      endcase
   end
endmodule

// ---- design/csa_sfr_decode.sv ----
// Special-function address decoder and bank base generator
`timescale 1ns/1ps
module csa_sfr_decode
   import csa_pkg::*;
(
   // Address and bank select
   input wire logic [7:0] i_addr,
   input wire logic [1:0] i_bank_sel,
   // Decoded selects
   output logic o_sel_sp,
   output logic o_sel_dpl,
   output logic o_sel_dph,
   output logic o_sel_psw,
   output logic o_sel_acc,
   output logic o_sel_b,
   output logic o_in_sfr,
   output logic o_bit_ok,
   output logic [7:0] o_bank_base
);
   // Register selects within direct space
   always_comb begin
      o_in_sfr = (i_addr >= SFR_SPACE_BASE); // RULE_10
      o_sel_sp = (i_addr == ADDR_STACK_TOP_POINTER); // RULE_05
      o_sel_dpl = (i_addr == ADDR_DATA_PTR_LOW_BYTE); // RULE_06
      o_sel_dph = (i_addr == ADDR_DATA_PTR_HIGH_BYTE); // RULE_07
      o_sel_psw = (i_addr == ADDR_PROGRAM_STATUS_WORD); // RULE_02
      o_sel_acc = (i_addr == ADDR_PRIMARY_WORKING_REGISTER); // RULE_03
      o_sel_b = (i_addr == ADDR_SECONDARY_OPERAND_REGISTER); // RULE_04
      o_bit_ok = o_in_sfr && (i_addr[2:0] == 3'h0); // RULE_10
      o_bank_base = {3'h0, i_bank_sel, 3'h0}; // RULE_01
   end
endmodule

// ---- design/csa_status_regs.sv ----
// Core working and status register file on the direct address space
//
// Functional notes
// RULE_01: The two bank-select bits of the status word pick bank 0..3 at base 0x00, 0x08, 0x10 or 0x18.
// RULE_02: The status word lives at 0xD0, is bit-addressable, clears to zero, and its two user flags are software bits.
// RULE_03: The primary working register lives at 0xE0, is bit-addressable, read-write and clears to zero.
// RULE_04: The secondary operand register lives at 0xF0, is bit-addressable, read-write and clears to zero.
// RULE_05: The stack pointer byte lives at 0x81.
// RULE_06: The data pointer low byte lives at 0x82.
// RULE_07: The data pointer high byte lives at 0x83.
// RULE_08: Unassigned special-function addresses are reserved with no defined function.
// RULE_09: Reserved bits reset to the default-state value, taken here as zero.
// RULE_10: Direct addresses 0x80..0xFF reach these registers; addresses ending in 0x0 or 0x8 also take bit access.
// RULE_11: Add and subtract set carry from bit 7 and aux carry from bit 3; other arithmetic clears both.
// RULE_12: Overflow flags signed add/sub overflow, wide products and divide by zero; parity shows odd parity of the primary register.
`timescale 1ns/1ps
module csa_status_regs
   import csa_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Direct byte access
   input wire logic [7:0] i_addr,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_data,
   // Bit access
   input wire logic i_bit_wr_en,
   input wire logic [2:0] i_bit_pos,
   input wire logic i_bit_val,
   // Arithmetic request
   input wire csa_pkg::csa_op_t i_op,
   input wire logic [7:0] i_opnd,
   // Read data
   output logic [7:0] o_rd_data,
   output logic o_rd_hit,
   // Register views
   output logic [7:0] o_primary_working_register,
   output logic [7:0] o_secondary_operand_register,
   output logic [7:0] o_program_status_word,
   output logic [7:0] o_stack_top_pointer,
   output logic [15:0] o_data_ptr,
   output logic [7:0] o_bank_base
);
   import csa_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Storage
   logic [7:0] primary_working_register;
   logic [7:0] secondary_operand_register;
   logic [7:0] stack_top_pointer;
   logic [7:0] data_ptr_low_byte;
   logic [7:0] data_ptr_high_byte;
   logic carry_flag;
   logic aux_carry_flag;
   logic user_flag_zero;
   logic bank_sel_hi;
   logic bank_sel_lo;
   logic arith_range_error_flag;
   logic user_flag_one;
   logic parity_flag;

   ////////////////////////////////////////////////////////////////////
   // Decode and arithmetic
   logic sel_sp;
   logic sel_dpl;
   logic sel_dph;
   logic sel_psw;
   logic sel_acc;
   logic sel_b;
   logic in_sfr;
   logic bit_ok;
   logic [7:0] acc_res;
   logic [7:0] b_res;
   logic b_wr;
   logic arith_carry;
   logic arith_aux;
   logic arith_range;
   logic arith_act;
   logic byte_wr;
   logic bit_wr;
   logic [7:0] psw_now;
   logic [7:0] bit_mask;

   csa_sfr_decode u_decode (
      .i_addr(i_addr),
      .i_bank_sel({bank_sel_hi, bank_sel_lo}),
      .o_sel_sp(sel_sp),
      .o_sel_dpl(sel_dpl),
      .o_sel_dph(sel_dph),
      .o_sel_psw(sel_psw),
      .o_sel_acc(sel_acc),
      .o_sel_b(sel_b),
      .o_in_sfr(in_sfr),
      .o_bit_ok(bit_ok),
      .o_bank_base(o_bank_base)
   );

   csa_arith_unit u_arith (
      .i_op(i_op),
      .i_acc(primary_working_register),
      .i_opnd(i_opnd),
      .i_breg(secondary_operand_register),
      .i_carry_in(carry_flag),
      .o_acc_res(acc_res),
      .o_b_res(b_res),
      .o_b_wr(b_wr),
      .o_carry(arith_carry),
      .o_aux_carry(arith_aux),
      .o_range_err(arith_range)
   );

   // Access qualifiers
   assign arith_act = (i_op != CSA_OP_NONE);
   assign byte_wr = i_wr_en && in_sfr; // RULE_10
   assign bit_wr = i_bit_wr_en && bit_ok; // RULE_10
   assign bit_mask = 8'h01 << i_bit_pos;
   assign psw_now = {carry_flag, aux_carry_flag, user_flag_zero,
      bank_sel_hi, bank_sel_lo, arith_range_error_flag, user_flag_one,
      parity_flag};

   ////////////////////////////////////////////////////////////////////
   // Primary working register
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         primary_working_register <= RST_PRIMARY_WORKING_REGISTER; // RULE_03
      end else if (byte_wr && sel_acc) begin
         primary_working_register <= i_wr_data; // RULE_03
      end else if (bit_wr && sel_acc) begin
         primary_working_register[i_bit_pos] <= i_bit_val; // RULE_03
      end else if (arith_act) begin
         primary_working_register <= acc_res;
      end
   end

   // Secondary operand register
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         secondary_operand_register <= RST_SECONDARY_OPERAND_REGISTER; // RULE_04
      end else if (byte_wr && sel_b) begin
         secondary_operand_register <= i_wr_data; // RULE_04
      end else if (bit_wr && sel_b) begin
         secondary_operand_register[i_bit_pos] <= i_bit_val; // RULE_04
      end else if (arith_act && b_wr) begin
         secondary_operand_register <= b_res; // RULE_04
      end
   end

   // Stack pointer
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         stack_top_pointer <= RST_STACK_TOP_POINTER;
      end else if (byte_wr && sel_sp) begin
         stack_top_pointer <= i_wr_data; // RULE_05
      end
   end

   // Data pointer bytes
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         data_ptr_low_byte <= RST_DATA_PTR;
         data_ptr_high_byte <= RST_DATA_PTR;
      end else begin
         if (byte_wr && sel_dpl) begin
            data_ptr_low_byte <= i_wr_data; // RULE_06
         end
         if (byte_wr && sel_dph) begin
            data_ptr_high_byte <= i_wr_data; // RULE_07
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status word: software write, bit write, then arithmetic flags
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         {carry_flag, aux_carry_flag, user_flag_zero, bank_sel_hi,
            bank_sel_lo, arith_range_error_flag,
            user_flag_one} <= RST_PROGRAM_STATUS_WORD[7:1]; // RULE_02
      end else if (byte_wr && sel_psw) begin
         carry_flag <= i_wr_data[POS_CARRY_FLAG];
         aux_carry_flag <= i_wr_data[POS_AUX_CARRY_FLAG];
         user_flag_zero <= i_wr_data[POS_USER_FLAG_ZERO]; // RULE_02
         bank_sel_hi <= i_wr_data[POS_BANK_SEL_HI]; // RULE_01
         bank_sel_lo <= i_wr_data[POS_BANK_SEL_LO]; // RULE_01
         arith_range_error_flag <= i_wr_data[POS_ARITH_RANGE_ERROR_FLAG];
         user_flag_one <= i_wr_data[POS_USER_FLAG_ONE]; // RULE_02
      end else if (bit_wr && sel_psw) begin
         carry_flag <= (bit_mask[POS_CARRY_FLAG]) ? i_bit_val : carry_flag;
         aux_carry_flag <= (bit_mask[POS_AUX_CARRY_FLAG]) ? i_bit_val
            : aux_carry_flag;
         user_flag_zero <= (bit_mask[POS_USER_FLAG_ZERO]) ? i_bit_val
            : user_flag_zero; // RULE_02
         bank_sel_hi <= (bit_mask[POS_BANK_SEL_HI]) ? i_bit_val
            : bank_sel_hi;
         bank_sel_lo <= (bit_mask[POS_BANK_SEL_LO]) ? i_bit_val
            : bank_sel_lo;
         arith_range_error_flag <= (bit_mask[POS_ARITH_RANGE_ERROR_FLAG])
            ? i_bit_val : arith_range_error_flag;
         user_flag_one <= (bit_mask[POS_USER_FLAG_ONE]) ? i_bit_val
            : user_flag_one; // RULE_02
      end else if (arith_act && i_op != CSA_OP_OTHER) begin
         carry_flag <= arith_carry; // RULE_11
         aux_carry_flag <= arith_aux; // RULE_11
         arith_range_error_flag <= arith_range; // RULE_12
      end else if (i_op == CSA_OP_OTHER) begin
         carry_flag <= 1'b0; // RULE_11
         aux_carry_flag <= 1'b0; // RULE_11
      end
   end

   // Parity follows the primary working register, read-only
   assign parity_flag = ^primary_working_register; // RULE_12

   ////////////////////////////////////////////////////////////////////
   // Read mux; reserved addresses read zero and flag a miss
   always_comb begin
      o_rd_data = 8'h00;
      o_rd_hit = 1'b1;
      if (sel_sp) begin
         o_rd_data = stack_top_pointer; // RULE_05
      end else if (sel_dpl) begin
         o_rd_data = data_ptr_low_byte; // RULE_06
      end else if (sel_dph) begin
         o_rd_data = data_ptr_high_byte; // RULE_07
      end else if (sel_psw) begin
         o_rd_data = psw_now; // RULE_02
      end else if (sel_acc) begin
         o_rd_data = primary_working_register; // RULE_03
      end else if (sel_b) begin
         o_rd_data = secondary_operand_register; // RULE_04
      end else begin
         o_rd_data = 8'h00; // RULE_08 RULE_09
         o_rd_hit = 1'b0; // RULE_08
      end
   end

   // Register views for the datapath
   assign o_primary_working_register = primary_working_register;
   assign o_secondary_operand_register = secondary_operand_register;
   assign o_program_status_word = psw_now;
   assign o_stack_top_pointer = stack_top_pointer;
   assign o_data_ptr = {data_ptr_high_byte, data_ptr_low_byte};
endmodule

// ---- verif/csa_status_regs_properties.sv ----
// Checker for the core status and working register file
`timescale 1ns/1ps
module csa_status_regs_properties
   import csa_pkg::*;
(
   // Clock, reset and requests
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_data,
   input wire logic i_bit_wr_en,
   input wire csa_pkg::csa_op_t i_op,
   input wire logic [7:0] i_opnd,
   // Read data and register views
   input wire logic [7:0] o_rd_data,
   input wire logic o_rd_hit,
   input wire logic [7:0] o_primary_working_register,
   input wire logic [7:0] o_secondary_operand_register,
   input wire logic [7:0] o_program_status_word,
   input wire logic [7:0] o_stack_top_pointer,
   input wire logic [15:0] o_data_ptr,
   input wire logic [7:0] o_bank_base
);
   logic [7:0] acc;
   logic [7:0] program_status_word;
   logic [8:0] sum;
   logic [4:0] half;
   logic [15:0] prod;

   // Short names and reference arithmetic
   assign acc = o_primary_working_register;
   assign program_status_word = o_program_status_word;
   assign sum = {1'b0, acc} + {1'b0, i_opnd};
   assign half = {1'b0, acc[3:0]} + {1'b0, i_opnd[3:0]};
   assign prod = acc * o_secondary_operand_register;

   default clocking @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   ////////////////////////////////////////////////////////////////////////
   // Operation issue steps with no competing write
   sequence s_add;
      i_op == CSA_OP_ADD && !i_wr_en && !i_bit_wr_en;
   endsequence
   sequence s_mul;
      i_op == CSA_OP_MUL && !i_wr_en && !i_bit_wr_en;
   endsequence

   property p_bank_base;
      o_bank_base == {3'h0, program_status_word[4:3], 3'h0};
   endproperty
   property p_psw_wr;
      i_wr_en && i_addr == ADDR_PROGRAM_STATUS_WORD
         |=> program_status_word[7:1] == $past(i_wr_data[7:1]);
   endproperty
   property p_acc_wr;
      i_wr_en && i_addr == ADDR_PRIMARY_WORKING_REGISTER
         |=> acc == $past(i_wr_data);
   endproperty
   property p_b_rd;
      i_addr == ADDR_SECONDARY_OPERAND_REGISTER
         |-> o_rd_hit && o_rd_data == o_secondary_operand_register;
   endproperty
   property p_sp_wr;
      i_wr_en && i_addr == ADDR_STACK_TOP_POINTER
         |=> o_stack_top_pointer == $past(i_wr_data);
   endproperty
   property p_dpl_wr;
      i_wr_en && i_addr == ADDR_DATA_PTR_LOW_BYTE
         |=> o_data_ptr[7:0] == $past(i_wr_data);
   endproperty
   property p_dph_wr;
      i_wr_en && i_addr == ADDR_DATA_PTR_HIGH_BYTE
         |=> o_data_ptr[15:8] == $past(i_wr_data);
   endproperty
   property p_unmapped;
      !(i_addr inside {8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0})
         |-> !o_rd_hit && o_rd_data == 8'h00;
   endproperty
   property p_reset;
      $fell(i_rst) |-> acc == 8'h00 && program_status_word == 8'h00
         && o_stack_top_pointer == 8'h07 && o_data_ptr == 16'h0000;
   endproperty
   property p_sp_bit;
      i_bit_wr_en && !i_wr_en && i_addr == ADDR_STACK_TOP_POINTER
         |=> $stable(o_stack_top_pointer);
   endproperty
   property p_add;
      s_add |=> program_status_word[7] == $past(sum[8]) && program_status_word[6] == $past(half[4]);
   endproperty
   property p_mul;
      s_mul |=> program_status_word[2] == $past(|prod[15:8]) && program_status_word[7:6] == 2'h0
         && acc == $past(prod[7:0]);
   endproperty
   property p_parity;
      program_status_word[0] == ^acc;
   endproperty

   ////////////////////////////////////////////////////////////////////////
   a_bank_base: assert property (p_bank_base)
      else $error("bank base wrong");
   a_psw_wr: assert property (p_psw_wr)
      else $error("status word write lost");
   a_acc_wr: assert property (p_acc_wr)
      else $error("primary register write lost");
   a_b_rd: assert property (p_b_rd)
      else $error("secondary register read wrong");
   a_sp_wr: assert property (p_sp_wr)
      else $error("stack pointer write lost");
   a_dpl_wr: assert property (p_dpl_wr)
      else $error("pointer low write lost");
   a_dph_wr: assert property (p_dph_wr)
      else $error("pointer high write lost");
   a_unmapped: assert property (p_unmapped)
      else $error("reserved address answered");
   a_reset: assert property (p_reset)
      else $error("reset value wrong");
   a_sp_bit: assert property (p_sp_bit)
      else $error("bit write reached byte-only register");
   a_add: assert property (p_add)
      else $error("add carry flags wrong");
   a_mul: assert property (p_mul)
      else $error("multiply result or flags wrong");
   a_parity: assert property (p_parity)
      else $error("parity wrong");
endmodule

bind csa_status_regs csa_status_regs_properties i_csa_status_regs_properties (
   .i_core_clk, .i_rst, .i_addr, .i_wr_en, .i_wr_data, .i_bit_wr_en,
   .i_op, .i_opnd, .o_rd_data, .o_rd_hit, .o_primary_working_register,
   .o_secondary_operand_register, .o_program_status_word,
   .o_stack_top_pointer, .o_data_ptr, .o_bank_base
);

// ---- verif/csa_status_regs_tb_top.sv ----
// Testbench for the core status and working register file
`timescale 1ns/1ps
module csa_status_regs_tb_top;
   import csa_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic i_wr_en = 1'b0;
   logic [7:0] i_wr_data = 8'h00;
   logic i_bit_wr_en = 1'b0;
   logic [2:0] i_bit_pos = 3'h0;
   logic i_bit_val = 1'b0;
   csa_op_t i_op = CSA_OP_NONE;
   logic [7:0] i_opnd = 8'h00;
   logic [7:0] o_rd_data, o_primary_working_register, o_bank_base;
   logic [7:0] o_secondary_operand_register, o_program_status_word;
   logic [7:0] o_stack_top_pointer;
   logic o_rd_hit;
   logic [15:0] o_data_ptr;
   logic [7:0] regs [6] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0};
   logic [7:0] v;
   int fail_count = 0;
   int n_compared = 0;

   // Free-running core clock
   always #50 i_core_clk = ~i_core_clk;

   csa_status_regs i_csa_status_regs (
      .i_core_clk, .i_rst, .i_addr, .i_wr_en, .i_wr_data, .i_bit_wr_en,
      .i_bit_pos, .i_bit_val, .i_op, .i_opnd, .o_rd_data, .o_rd_hit,
      .o_primary_working_register, .o_secondary_operand_register,
      .o_program_status_word, .o_stack_top_pointer, .o_data_ptr,
      .o_bank_base
   );

   ////////////////////////////////////////////////////////////////////////
   // Compare and access tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step();
      @(posedge i_core_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      step();
      i_addr = a;
      i_wr_data = d;
      i_wr_en = 1'b1;
      step();
      i_wr_en = 1'b0;
   endtask
   task automatic bwr(input logic [7:0] a, input logic [2:0] p, input logic b);
      step();
      i_addr = a;
      i_bit_pos = p;
      i_bit_val = b;
      i_bit_wr_en = 1'b1;
      step();
      i_bit_wr_en = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic h, input logic [7:0] e);
      step();
      i_addr = a;
      #5;
      check(o_rd_hit, h);
      check(o_rd_data, e);
   endtask
   // Load status, primary and operand, run one operation, check results
   task automatic ar(input csa_op_t op, input logic [7:0] p, a, n, ea, eb,
                     input logic [2:0] ef);
      wr(8'hd0, p);
      wr(8'he0, a);
      wr(8'hf0, n);
      step();
      i_op = op;
      i_opnd = n;
      step();
      i_op = CSA_OP_NONE;
      check(o_primary_working_register, ea);
      check(o_secondary_operand_register, eb);
      check({o_program_status_word[7:6], o_program_status_word[2]}, ef);
      check(o_program_status_word[0], ^ea);
   endtask
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Hang guard
   initial begin
      repeat (5000) @(posedge i_core_clk);
      fail_count++;
      finish_test();
   end

   // Main sequence
   initial begin
      repeat (10) @(posedge i_core_clk);
      #1;
      i_rst = 1'b0;
      rd(8'h81, 1'b1, 8'h07);
      rd(8'h83, 1'b1, 8'h00);
      rd(8'hd0, 1'b1, 8'h00);
      rd(8'he0, 1'b1, 8'h00);
      rd(8'hf0, 1'b1, 8'h00);
      for (int k = 0; k < 6; k++) begin
         v = 8'h11 * 8'(k + 1);
         wr(regs[k], v);
         rd(regs[k], 1'b1, v);
      end
      check(o_data_ptr, 16'h3322);
      wr(8'hd0, 8'hff);
      rd(8'hd0, 1'b1, 8'hfe);
      wr(8'he0, 8'h01);
      rd(8'hd0, 1'b1, 8'hff);
      for (int k = 0; k < 4; k++) begin
         wr(8'hd0, 8'(k * 8));
         check(o_bank_base, 8'(k * 8));
      end
      wr(8'hd0, 8'h00);
      bwr(8'hd0, 3'h5, 1'b1);
      bwr(8'hd0, 3'h1, 1'b1);
      check(o_program_status_word, 8'h23);
      bwr(8'he0, 3'h7, 1'b1);
      check(o_primary_working_register, 8'h81);
      bwr(8'hf0, 3'h0, 1'b1);
      check(o_secondary_operand_register, 8'h67);
      bwr(8'h81, 3'h0, 1'b0);
      check(o_stack_top_pointer, 8'h11);
      wr(8'h84, 8'ha5);
      rd(8'h84, 1'b0, 8'h00);
      rd(8'hd1, 1'b0, 8'h00);
      rd(8'h7f, 1'b0, 8'h00);
      wr(8'h60, 8'hee);
      check(o_primary_working_register, 8'h81);
      ar(CSA_OP_ADD, 8'h00, 8'h05, 8'hfb, 8'h00, 8'hfb, 3'h6);
      ar(CSA_OP_ADD, 8'h00, 8'h7f, 8'h01, 8'h80, 8'h01, 3'h3);
      ar(CSA_OP_ADDC, 8'h80, 8'h10, 8'h01, 8'h12, 8'h01, 3'h0);
      ar(CSA_OP_SUBB, 8'h00, 8'h10, 8'h01, 8'h0f, 8'h01, 3'h2);
      ar(CSA_OP_SUBB, 8'h80, 8'h00, 8'h00, 8'hff, 8'h00, 3'h6);
      ar(CSA_OP_SUBB, 8'h00, 8'h80, 8'h01, 8'h7f, 8'h01, 3'h3);
      ar(CSA_OP_MUL, 8'hc0, 8'h20, 8'h10, 8'h00, 8'h02, 3'h1);
      ar(CSA_OP_MUL, 8'hc4, 8'h0f, 8'h11, 8'hff, 8'h00, 3'h0);
      ar(CSA_OP_DIV, 8'hc0, 8'h25, 8'h00, 8'h25, 8'h00, 3'h1);
      ar(CSA_OP_DIV, 8'hc4, 8'h25, 8'h04, 8'h09, 8'h01, 3'h0);
      ar(CSA_OP_OTHER, 8'hc4, 8'h33, 8'h00, 8'h33, 8'h00, 3'h1);
      finish_test();
   end
endmodule
